// File: src/hpl_phy_link.v
// phy side of the phy/link packet receive and transmit handshake
//
// Operation
// RULE_01 - receive starts by driving receive on the control pair, after idle.
// RULE_02 - data-on pattern, all ones, may precede the speed code for cycles.
// RULE_03 - one speed code cycle before data; s100, s200, s400; unused bits zero.
// RULE_04 - link decodes first non data-on byte, drops data on bad speed.
// RULE_05 - packet data follows speed code, receive held for every remaining cycle.
// RULE_06 - reception ends with idle, kept at least one cycle before anything else.
// RULE_07 - null packet: receive with data-on only, then idle, no speed code.
// RULE_08 - on winning arbitration drive grant one cycle, then one idle cycle.
// RULE_09 - after that idle cycle release control pair and data lines.
// RULE_10 - link drives idle, hold or transmit; at most one idle before hold.
// RULE_11 - link may hold a bounded number of cycles before transmit.
// RULE_12 - device sends data-prefix on the bus while link idles or holds.
// RULE_13 - link drives transmit with data until final bits sent.
// RULE_14 - link ends with hold or idle, one more idle, then releases.
// RULE_15 - ending hold means concatenation: wait packet gap, grant again.
// RULE_16 - speed fixed per ownership unless multispeed concat gives speed on hold.
// RULE_17 - link never concatenates s100 after a faster packet.
// RULE_18 - link releases with two idles; device drives idle one clock after.
// RULE_19 - after regaining interface device drives at least one idle cycle.
// RULE_20 - each direction change includes one extra clock period.
// RULE_22 - both sides launch and sample on rising clock, inputs registered.
// RULE_21 - a link bus request makes the device arbitrate before granting.
`include "hpl_link_map.vh"
`default_nettype none

// two-entry buffer: a stall by the drain side loses no word
module hpl_buf #(
   parameter W = 9
) (
   input  wire         clk,
   input  wire         rst,
   input  wire         in_valid,
   output wire         in_ready,
   input  wire [W-1:0] in_data,
   output wire         out_valid,
   input  wire         out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:1];
   reg         wr_ptr;
   reg         rd_ptr;
   reg [1:0]   cnt;
   wire        push;
   wire        pop;

   assign in_ready  = (cnt != `HPL_CNT_FULL);
   assign out_valid = (cnt != `HPL_CNT_ZERO);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // storage written by index, no reset needed on the data
   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill count
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         cnt    <= `HPL_CNT_ZERO;
      end else begin
         if (push) wr_ptr <= ~wr_ptr;
         if (pop) rd_ptr <= ~rd_ptr;
         if (push & ~pop) cnt <= cnt + 2'h1;
         else if (pop & ~push) cnt <= cnt - 2'h1;
      end
   end
endmodule // hpl_buf

module hpl_phy_link (
   input  wire       clk,
   input  wire       rst,
   // link-facing pins
   input  wire [1:0] ctl_in,
   output reg  [1:0] ctl_out,
   output reg        ctl_oe,
   input  wire [7:0] d_in,
   output reg  [7:0] d_out,
   output reg        d_oe,
   input  wire       link_request_line,
   // serial bus receive side
   input  wire       rx_start,
   input  wire       rx_null,
   input  wire [1:0] rx_speed,
   input  wire       rx_valid,
   output wire       rx_ready,
   input  wire [7:0] rx_data,
   input  wire       rx_last,
   // arbitration and transmit side
   output reg        arb_req,
   input  wire       arb_won,
   input  wire [1:0] arb_speed,
   input  wire       gap_done,
   input  wire       multispeed_concat_enable,
   output reg        tx_prefix,
   output reg        tx_valid,
   output reg  [7:0] tx_data,
   output reg        tx_end,
   output reg        tx_concat,
   output reg  [1:0] tx_speed
);
   localparam ST_IDLE    = 4'h0;
   localparam ST_RX_ON   = 4'h1;
   localparam ST_RX_SPD  = 4'h2;
   localparam ST_RX_DATA = 4'h3;
   localparam ST_RX_END  = 4'h4;
   localparam ST_GRANT   = 4'h5;
   localparam ST_GIDLE   = 4'h6;
   localparam ST_LINK    = 4'h7;
   localparam ST_RETAKE  = 4'h8;
   localparam ST_CWAIT   = 4'h9;

   reg  [3:0] state;
   reg  [3:0] next_state;
   reg  [1:0] next_ctl;
   reg  [7:0] next_d;
   reg        next_oe;
   reg        pop;
   reg  [1:0] ctl_r;
   reg  [7:0] d_r;
   reg        req_r;
   reg        req_pend;
   reg        null_pend;
   reg  [7:0] rx_spd_code;
   reg        sent_last;
   reg        started;
   reg        ended;
   reg        concat_pend;
   reg        owned;
   reg  [1:0] idle_run;
   reg  [1:0] turn;
   reg  [1:0] hold_spd;
   wire       bq_valid;
   wire [8:0] bq_data;

   // receive words wait here until the speed code has gone out
   hpl_buf #(
      .W (`HPL_BUF_W)
   ) u_rxbuf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .in_data   ({rx_last, rx_data}),
      .out_valid (bq_valid),
      .out_ready (pop),
      .out_data  (bq_data)
   );

   // control and data pins registered before any decision
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         ctl_r <= `HPL_LCTL_IDLE;
         d_r   <= `HPL_D_ZERO;
         req_r <= 1'b0;
      end else begin
         ctl_r <= ctl_in;                                  // [RULE_22]
         d_r   <= d_in;                                    // [RULE_22]
         req_r <= link_request_line;
      end
   end

   // speed code of the coming reception
   always @* begin
      case (rx_speed)
         `HPL_SPEED_S200: rx_spd_code = `HPL_D_SPD_S200;   // [RULE_03]
         `HPL_SPEED_S400: rx_spd_code = `HPL_D_SPD_S400;   // [RULE_03]
         default:         rx_spd_code = `HPL_D_SPD_S100;   // [RULE_03]
      endcase
   end

   // speed code the link puts on the data lines with its ending hold
   always @* begin
      if ((d_r & `HPL_SPD_MASK_HI) == `HPL_SPD_KEY_HI) hold_spd = `HPL_SPEED_S100;
      else if ((d_r & `HPL_SPD_MASK_LO) == `HPL_D_SPD_S200) hold_spd = `HPL_SPEED_S200;
      else hold_spd = `HPL_SPEED_S400;
   end

   // next state and the pin values to launch with it
   always @* begin
      next_state = state;
      next_ctl   = `HPL_CTL_IDLE;
      next_d     = `HPL_D_ZERO;
      next_oe    = 1'b1;
      pop        = 1'b0;
      case (state)
         ST_IDLE, ST_RX_END: begin
            // rx_end already gave one idle cycle; idle itself is the gap
            if (state == ST_RX_END) begin
               next_state = ST_IDLE;                       // [RULE_06]
            end else if (rx_start) begin
               next_state = ST_RX_ON;
               next_ctl   = `HPL_CTL_RECEIVE;              // [RULE_01]
               next_d     = `HPL_D_DATA_ON;                // [RULE_02]
            end else if (arb_won & req_pend) begin
               next_state = ST_GRANT;
               next_ctl   = `HPL_CTL_GRANT;                // [RULE_08]
            end
         end
         ST_RX_ON: begin
            if (null_pend) begin
               next_state = ST_RX_END;                     // [RULE_07]
            end else if (bq_valid) begin
               next_state = ST_RX_SPD;
               next_ctl   = `HPL_CTL_RECEIVE;
               next_d     = rx_spd_code;                   // [RULE_03]
            end else begin
               next_ctl   = `HPL_CTL_RECEIVE;
               next_d     = `HPL_D_DATA_ON;                // [RULE_02]
            end
         end
         ST_RX_SPD, ST_RX_DATA: begin
            if (state == ST_RX_DATA && sent_last) begin
               next_state = ST_RX_END;                     // [RULE_06]
            end else begin
               next_state = ST_RX_DATA;
               next_ctl   = `HPL_CTL_RECEIVE;              // [RULE_05]
               pop        = bq_valid;
               // an underrun repeats the last byte; the source must keep pace
               next_d     = bq_valid ? bq_data[7:0] : d_out; // [RULE_05]
            end
         end
         ST_GRANT: begin
            next_state = ST_GIDLE;                         // [RULE_08]
         end
         ST_GIDLE: begin
            next_state = ST_LINK;
            next_oe    = 1'b0;                             // [RULE_09] [RULE_20]
         end
         ST_LINK: begin
            next_oe = 1'b0;
            // first two registered samples are our own idle and the floating pins
            if (turn != `HPL_TURN_DONE) begin
               next_state = ST_LINK;                       // [RULE_20]
            end else if (ended && ctl_r == `HPL_LCTL_IDLE) begin
               next_state = ST_RETAKE;                     // [RULE_18]
               next_oe    = 1'b1;
            end else if (!started && ctl_r == `HPL_LCTL_IDLE && idle_run == `HPL_ONE_IDLE) begin
               next_state = ST_RETAKE;                     // [RULE_18]
               next_oe    = 1'b1;
            end
         end
         ST_RETAKE: begin
            next_state = concat_pend ? ST_CWAIT : ST_IDLE; // [RULE_19]
         end
         ST_CWAIT: begin
            if (gap_done) begin
               next_state = ST_GRANT;                      // [RULE_15]
               next_ctl   = `HPL_CTL_GRANT;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // state and launched pin values, all from flip-flops
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         state   <= ST_IDLE;
         ctl_out <= `HPL_CTL_IDLE;
         d_out   <= `HPL_D_ZERO;
         ctl_oe  <= 1'b1;
         d_oe    <= 1'b1;
      end else begin
         state   <= next_state;
         ctl_out <= next_ctl;
         d_out   <= next_d;
         ctl_oe  <= next_oe;                               // [RULE_09]
         d_oe    <= next_oe;                               // [RULE_09]
      end
   end

   // receive bookkeeping: null request and last byte sent
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         null_pend <= 1'b0;
         sent_last <= 1'b0;
      end else begin
         // a null request in the clearing cycle still wins
         if (rx_null) null_pend <= 1'b1;                   // [RULE_07]
         else if (next_state == ST_RX_END) null_pend <= 1'b0;
         if (pop) sent_last <= bq_data[`HPL_BUF_LAST];
         else if (state != ST_RX_DATA) sent_last <= 1'b0;
      end
   end

   // bus request from the link starts arbitration
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         req_pend <= 1'b0;
         arb_req  <= 1'b0;
      end else begin
         if (link_request_line & ~req_r) req_pend <= 1'b1; // [RULE_21]
         else if (next_state == ST_GRANT && state != ST_CWAIT) req_pend <= 1'b0;
         arb_req <= (link_request_line & ~req_r) | (req_pend & ~(next_state == ST_GRANT)); // [RULE_21]
      end
   end

   // follow the link while it owns the interface
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         started     <= 1'b0;
         ended       <= 1'b0;
         idle_run    <= `HPL_CNT_ZERO;
         turn        <= `HPL_CNT_ZERO;
         concat_pend <= 1'b0;
         owned       <= 1'b0;
         tx_prefix   <= 1'b0;
         tx_valid    <= 1'b0;
         tx_data     <= `HPL_D_ZERO;
         tx_end      <= 1'b0;
         tx_concat   <= 1'b0;
         tx_speed    <= `HPL_SPEED_S100;
      end else begin
         tx_valid  <= 1'b0;
         tx_end    <= 1'b0;
         tx_prefix <= 1'b0;
         if (state == ST_GRANT) begin
            started     <= 1'b0;
            ended       <= 1'b0;
            idle_run    <= `HPL_CNT_ZERO;
            concat_pend <= 1'b0;
            turn        <= `HPL_CNT_ZERO;
            // speed is fixed on the first grant of an ownership
            if (!owned) tx_speed <= arb_speed;             // [RULE_16]
            owned <= 1'b1;
         end else if (state == ST_LINK && turn != `HPL_TURN_DONE) begin
            // no prefix or idle count from pins the link does not drive yet
            turn <= turn + 2'h1;                           // [RULE_20]
         end else if (state == ST_LINK && !ended) begin
            if (ctl_r == `HPL_LCTL_XMIT) begin
               started  <= 1'b1;
               tx_valid <= 1'b1;                           // [RULE_13]
               tx_data  <= d_r;
            end else if (started) begin
               ended       <= 1'b1;                        // [RULE_14]
               tx_end      <= 1'b1;
               concat_pend <= (ctl_r == `HPL_LCTL_HOLD);   // [RULE_15]
               tx_concat   <= (ctl_r == `HPL_LCTL_HOLD);
               if (ctl_r == `HPL_LCTL_HOLD && multispeed_concat_enable) begin
                  tx_speed <= hold_spd;                    // [RULE_16]
               end
            end else begin
               tx_prefix <= 1'b1;                          // [RULE_12]
               if (ctl_r == `HPL_LCTL_IDLE) idle_run <= idle_run + 2'h1;
               else idle_run <= `HPL_CNT_ZERO;
            end
         end else if (state == ST_IDLE) begin
            owned     <= 1'b0;
            tx_concat <= 1'b0;
         end
      end
   end
endmodule // hpl_phy_link
`default_nettype wire

// File: include/hpl_link_map.vh
// constants for the phy side of the phy/link packet interface
`ifndef HPL_LINK_MAP_VH
`define HPL_LINK_MAP_VH

// control pair codes, device driving
`define HPL_CTL_IDLE     2'h0
`define HPL_CTL_STATUS   2'h1
`define HPL_CTL_RECEIVE  2'h2
`define HPL_CTL_GRANT    2'h3

// control pair codes, link driving
`define HPL_LCTL_IDLE    2'h0
`define HPL_LCTL_HOLD    2'h1
`define HPL_LCTL_XMIT    2'h2

// data line patterns
`define HPL_D_DATA_ON    8'hff
`define HPL_D_SPD_S100   8'h00
`define HPL_D_SPD_S200   8'h40
`define HPL_D_SPD_S400   8'h50
`define HPL_D_ZERO       8'h00

// speed code decode masks and keys
`define HPL_SPD_MASK_HI  8'hc0
`define HPL_SPD_MASK_LO  8'hf0
`define HPL_SPD_KEY_HI   8'h00

// speed selectors on the user side
`define HPL_SPEED_S100   2'h0
`define HPL_SPEED_S200   2'h1
`define HPL_SPEED_S400   2'h2

// idle cycles from the link that cancel a grant
`define HPL_CANCEL_IDLES 2'h2
`define HPL_ONE_IDLE     2'h1

// registered samples to skip after letting go of the pins
`define HPL_TURN_DONE    2'h2

// buffer geometry and reset values
`define HPL_BUF_W        9
`define HPL_BUF_LAST     8
`define HPL_CNT_FULL     2'h2
`define HPL_CNT_ZERO     2'h0

`endif

// File: sim/hpl_phy_link_assertions.sv
// assertion checker for the phy side of the packet interface
`include "hpl_link_map.vh"
`default_nettype none
module hpl_phy_link_assertions (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [1:0] ctl_in,
   input wire logic [1:0] ctl_out,
   input wire logic       ctl_oe,
   input wire logic [7:0] d_in,
   input wire logic [7:0] d_out,
   input wire logic       d_oe,
   input wire logic       tx_prefix,
   input wire logic       tx_valid,
   input wire logic [7:0] tx_data
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // ctl_in only means something while the link owns the pins
   wire rcv = ctl_oe && ctl_out == `HPL_CTL_RECEIVE;
   wire rdo = rcv && d_out == `HPL_D_DATA_ON;
   wire lnk = !ctl_oe;
   wire lx  = lnk && ctl_in == `HPL_LCTL_XMIT;
   wire idl = ctl_oe && ctl_out == `HPL_CTL_IDLE;
   sequence s_grant;
      ctl_oe && ctl_out == `HPL_CTL_GRANT;
   endsequence
   sequence s_handoff;
      idl ##1 lnk;
   endsequence
   AST_GRANT: assert property (s_grant |=> s_handoff)
      else $error("grant not followed by idle and release");
   AST_OE_PAIR: assert property (d_oe == ctl_oe)
      else $error("data and control enables differ");
   AST_RX_START: assert property (rcv && !$past(rcv) |-> d_out == `HPL_D_DATA_ON)
      else $error("receive did not open with data-on");
   AST_SPEED: assert property (
      rcv && $past(rdo) && d_out != `HPL_D_DATA_ON |-> d_out inside {8'h00, 8'h40, 8'h50})
      else $error("bad speed code after data-on");
   AST_RX_END: assert property (idl && $past(rcv) |=> idl)
      else $error("no idle gap after reception");
   AST_RETAKE: assert property ($rose(ctl_oe) |-> idl ##1 idl)
      else $error("no idle after regaining the pins");
   AST_RELEASE: assert property (
      lnk && $past(lnk) && ctl_in == `HPL_LCTL_IDLE && $past(ctl_in) == `HPL_LCTL_IDLE |-> ##2 idl)
      else $error("pins not retaken two cycles after link release");
   AST_TX_BYTE: assert property (lx |-> ##2 tx_valid && tx_data == $past(d_in, 2))
      else $error("transmit byte lost or wrong");
   AST_TX_ONLY: assert property (tx_valid |-> $past(lx, 2))
      else $error("byte without transmit");
   AST_PREFIX: assert property (
      lnk && $past(lnk) && ctl_in == `HPL_LCTL_HOLD && $past(ctl_in) != `HPL_LCTL_XMIT |-> ##2 tx_prefix)
      else $error("no data-prefix during hold");
endmodule // hpl_phy_link_assertions

bind hpl_phy_link hpl_phy_link_assertions u_chk (.clk(clk), .rst(rst), .ctl_in(ctl_in), .ctl_out(ctl_out),
   .ctl_oe(ctl_oe), .d_in(d_in), .d_out(d_out), .d_oe(d_oe), .tx_prefix(tx_prefix),
   .tx_valid(tx_valid), .tx_data(tx_data));
`default_nettype wire

// File: sim/hpl_link_model.sv
// behavioural link controller on the far side of the pins
`include "hpl_link_map.vh"
`default_nettype none
module hpl_link_model (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       phy_oe,
   input  wire logic       go,
   input  wire logic       cancel,
   input  wire logic       idle1,
   input  wire logic [3:0] holds,
   input  wire logic [3:0] nbytes,
   input  wire logic       end_hold,
   input  wire logic [7:0] base,
   input  wire logic [7:0] spd,
   output var  logic       req,
   output var  logic [1:0] l_ctl,
   output var  logic [7:0] l_d,
   output var  logic       l_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   logic        oe_q;
   logic        act;
   logic [5:0]  t;
   logic [5:0]  nx;
   logic [10:0] s;
   // symbol of step n as {oe, ctl, data}; a single idle bit keeps the leading idle to one
   function automatic logic [10:0] sym(input logic [5:0] n);
      logic [5:0] b;
      logic [5:0] c;
      b = {5'h00, idle1} + {2'h0, holds};
      c = b + {2'h0, nbytes};
      if (cancel) sym = (n < 6'h02) ? {1'b1, `HPL_LCTL_IDLE, 8'h00} : 11'h000;
      else if (n < {5'h00, idle1}) sym = {1'b1, `HPL_LCTL_IDLE, 8'h00};
      else if (n < b) sym = {1'b1, `HPL_LCTL_HOLD, 8'h00};
      else if (n < c) sym = {1'b1, `HPL_LCTL_XMIT, base + {2'h0, n - b}};
      else if (n == c) sym = end_hold ? {1'b1, `HPL_LCTL_HOLD, spd} : 11'h400;
      else if (n == c + 6'h01) sym = 11'h400;
      else sym = 11'h000;
   endfunction
   // start one edge after the phy lets go, so the turnaround has a spare cycle
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         oe_q <= 1'b1;
         act <= 1'b0;
         t <= 6'h00;
         req <= 1'b0;
         {l_oe, l_ctl, l_d} <= 11'h000;
      end else begin
         oe_q <= phy_oe;
         if (go) req <= 1'b1;
         if ((oe_q && !phy_oe) || act) begin
            nx = act ? t : 6'h00;
            s = sym(nx);
            {l_oe, l_ctl, l_d} <= s;
            act <= s[10];
            t <= nx + 6'h01;
            req <= 1'b0;
         end
      end
   end
endmodule // hpl_link_model
`default_nettype wire

// File: sim/phy_link_packet_transfer_tb_top.sv
// self-checking bench for the phy side of the packet interface
`include "hpl_link_map.vh"
`default_nettype none
module phy_link_packet_transfer_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk, rst, rx_start, rx_null, rx_valid, rx_last, arb_won, gap_done, mce, req;
   logic       ctl_oe, d_oe, rx_ready, arb_req, tx_prefix, tx_valid, tx_end, tx_concat, l_oe;
   logic       go, cancel, idle1, end_hold;
   logic [1:0] rx_speed, arb_speed, ctl_out, tx_speed, ctl_w, l_ctl, lst_c;
   logic [3:0] holds, nbytes;
   logic [7:0] d_out, rx_data, tx_data, d_w, l_d, lst_d, base, spd;
   integer     seed;
   int         miscompares, checks_done, m, w, np;
   logic       lo;
   // undriven pins read as the inverse of their last level
   assign ctl_w = ctl_oe ? ctl_out : (l_oe ? l_ctl : ~lst_c);
   assign d_w = d_oe ? d_out : (l_oe ? l_d : ~lst_d);
   always @(posedge clk) begin
      if (ctl_oe || l_oe) begin
         lst_c <= ctl_w;
         lst_d <= d_w;
      end
   end
   hpl_phy_link dut (.clk(clk), .rst(rst), .ctl_in(ctl_w), .ctl_out(ctl_out), .ctl_oe(ctl_oe), .d_in(d_w),
      .d_out(d_out), .d_oe(d_oe), .link_request_line(req), .rx_start(rx_start), .rx_null(rx_null),
      .rx_speed(rx_speed), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
      .arb_req(arb_req), .arb_won(arb_won), .arb_speed(arb_speed), .gap_done(gap_done),
      .multispeed_concat_enable(mce), .tx_prefix(tx_prefix), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_end(tx_end), .tx_concat(tx_concat), .tx_speed(tx_speed));
   hpl_link_model u_link (.clk(clk), .rst(rst), .phy_oe(ctl_oe), .go(go), .cancel(cancel), .idle1(idle1),
      .holds(holds), .nbytes(nbytes), .end_hold(end_hold), .base(base), .spd(spd), .req(req),
      .l_ctl(l_ctl), .l_d(l_d), .l_oe(l_oe));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic tmo;
      miscompares++;
      report_and_stop();
   endtask
   function automatic logic [7:0] spd_code(input logic [1:0] s);
      return (s == `HPL_SPEED_S100) ? 8'h00 : ((s == `HPL_SPEED_S200) ? 8'h40 : 8'h50);
   endfunction
   // one reception; words are offered every cycle so the two-entry buffer fills
   task automatic rx_pkt(input logic [1:0] s, input int n, input logic nul);
      logic [7:0] q[$];
      logic [7:0] seen[$];
      int k;
      int i;
      logic acc, full, dn;
      for (k = 0; k < n; k++) q.push_back(8'($random(seed)));
      k = 0;
      full = 1'b0;
      dn = 1'b0;
      rx_start <= 1'b1;
      rx_null <= nul;
      rx_speed <= s;
      rx_valid <= (n > 0);
      rx_data <= (n > 0) ? q[0] : 8'h00;
      rx_last <= (n == 1);
      for (i = 0; i < 200 && !dn; i++) begin
         @(negedge clk);
         acc = rx_valid && rx_ready === 1'b1;
         if (rx_ready !== 1'b1) full = 1'b1;
         if (ctl_oe === 1'b1 && ctl_out === `HPL_CTL_RECEIVE) seen.push_back(d_out);
         else dn = seen.size() > 0;
         @(posedge clk);
         rx_start <= 1'b0;
         rx_null <= 1'b0;
         if (acc) begin
            k++;
            rx_valid <= (k < n);
            rx_data <= (k < n) ? q[k] : 8'h00;
            rx_last <= (k == n - 1);
         end
      end
      if (!dn) tmo();
      check("data-on", seen[0], 8'hff);
      k = 0;
      while (k < seen.size() && seen[k] === 8'hff) k++;
      if (nul) check("null tail", seen.size() - k, 0);
      else begin
         check("speed code", seen[k], spd_code(s));
         check("rx length", seen.size() - k - 1, n);
         for (i = 0; i < n; i++) check("rx byte", seen[k + 1 + i], q[i]);
         if (n > 2) check("buffer refused", full, 1'b1);
      end
      repeat (3) @(posedge clk);
   endtask
   // one transmitted packet seen from the user side
   task automatic tx_pkt(input logic first, input logic i1, input logic [3:0] h, input logic [3:0] nb,
                         input logic eh, input logic [1:0] es);
      logic [7:0] got[$];
      int i;
      int p;
      logic dn, ar;
      idle1 <= i1;
      holds <= h;
      nbytes <= nb;
      end_hold <= eh;
      base <= 8'($random(seed));
      go <= first;
      p = 0;
      dn = 1'b0;
      ar = 1'b0;
      for (i = 0; i < 300 && !dn; i++) begin
         @(negedge clk);
         if (arb_req === 1'b1) ar = 1'b1;
         if (tx_valid === 1'b1) got.push_back(tx_data);
         if (tx_prefix === 1'b1) p++;
         dn = tx_end === 1'b1;
         if (dn) check("concat", tx_concat, eh);
         if (dn) check("tx speed", tx_speed, es);
         @(posedge clk);
         go <= 1'b0;
      end
      if (!dn) tmo();
      check("prefix cycles", p, i1 + h);
      check("tx count", got.size(), nb);
      check("arb request", ar, first);
      for (i = 0; i < nb; i++) check("tx byte", got[i], 8'(base + i));
   endtask
   initial begin
      seed = 32'hab6613af;
      {rst, rx_start, rx_null, rx_valid, rx_last, gap_done, mce, go, cancel, idle1, end_hold} = 11'h400;
      {rx_speed, arb_speed, holds, nbytes, rx_data, base} = 28'h0;
      spd = 8'h50;
      arb_won = 1'b1; // arbiter always ready: grants must still wait for a request
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (m = 0; m < 3; m++) rx_pkt(m, 3 + {$random(seed)} % 6, 1'b0);
      rx_pkt(`HPL_SPEED_S400, 1, 1'b0);
      rx_pkt(`HPL_SPEED_S100, 0, 1'b1);
      // concatenated pair, fixed speed then multispeed
      for (m = 0; m < 2; m++) begin
         mce <= m;
         arb_speed <= `HPL_SPEED_S200;
         // with multispeed on, the ending hold already carries the next speed
         tx_pkt(1'b1, 1'b1, 4'($random(seed)) & 4'h7, 4'h1 + (4'($random(seed)) & 4'h3), 1'b1,
                m ? `HPL_SPEED_S400 : `HPL_SPEED_S200);
         gap_done <= 1'b1;
         tx_pkt(1'b0, 1'b0, 4'h0, 4'h2, 1'b0, m ? `HPL_SPEED_S400 : `HPL_SPEED_S200);
         gap_done <= 1'b0;
         repeat (4) @(posedge clk);
      end
      tx_pkt(1'b1, 1'b1, 4'hf, 4'h1, 1'b0, `HPL_SPEED_S200);
      // cancelled transfer: two idles from the link, no bytes
      cancel <= 1'b1;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      np = 0;
      lo = 1'b0;
      for (w = 0; w < 100 && !(lo && ctl_oe === 1'b1); w++) begin
         @(negedge clk);
         if (tx_valid === 1'b1) np++;
         if (ctl_oe === 1'b0) lo = 1'b1;
      end
      check("cancel bytes", np, 0);
      check("cancel retake", {lo, ctl_oe}, 2'h3);
      report_and_stop();
   end
endmodule // phy_link_packet_transfer_tb_top
`default_nettype wire
